// ==== common/atp_pkg.sv ====
package atp_pkg;
	// Byte addresses of the register words
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h070;
	localparam logic [11:0] ADDR_CONTROL = 12'h0b0;
	localparam logic [11:0] ADDR_COUNT = 12'h0b4;
	localparam logic [11:0] ADDR_COMPARE = 12'h0b8;
	localparam logic [11:0] ADDR_ASYNC_STATUS = 12'h0bc;
	localparam logic [11:0] ADDR_FLAGS = 12'h0c0;
	localparam logic [11:0] ADDR_GEN_CONTROL = 12'h0c4;
	// Control word fields
	localparam int CTL_FORCE_BIT = 7;
	localparam int CTL_WGM0_BIT = 6;
	localparam int CTL_COM_HI = 5;
	localparam int CTL_COM_LO = 4;
	localparam int CTL_WGM1_BIT = 3;
	localparam int CTL_CS_HI = 2;
	localparam int CTL_CS_LO = 0;
	// Flag and mask bit positions
	localparam int COMPARE_BIT = 1;
	localparam int OVERFLOW_BIT = 0;
	// Async status fields
	localparam int EXT_CLK_BIT = 4;
	localparam int ASYNC_SEL_BIT = 3;
	localparam int CNT_BUSY_BIT = 2;
	localparam int CMP_BUSY_BIT = 1;
	localparam int CTL_BUSY_BIT = 0;
	// General control field
	localparam int PSR_BIT = 1;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	// Counter limits
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	// Oscillator edges before a temporary value lands
	localparam logic [1:0] COMMIT_EDGES = 2'h2;
	localparam int PRESCALE_BITS = 10;
	// Waveform modes
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_PHASE_PWM = 2'h1;
	localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
	localparam logic [1:0] WGM_FAST_PWM = 2'h3;
endpackage : atp_pkg

// ==== hdl/atp_timer.sv ====
`timescale 1ns/100ps
module atp_timer (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Oscillator pins and their port fallback
	input wire logic OSC_IN_PIN,
	output logic OSC_PINS_DETACHED,
	output logic EXT_CLOCK_ENABLE,
	// Compare output pin
	input wire logic PORT_OUT,
	input wire logic PORT_DIR,
	output logic WAVE_OUT_PIN,
	output logic WAVE_OUT_OE,
	// Interrupt request side
	input wire logic GLOBAL_IRQ_EN,
	input wire logic COMPARE_VECTOR_ACK,
	input wire logic OVERFLOW_VECTOR_ACK,
	output logic COMPARE_IRQ,
	output logic OVERFLOW_IRQ
);

	logic [7:0] control, control_tmp, count, compare, compare_buf, compare_tmp, count_tmp;
	logic [7:0] irq_mask;
	logic [1:0] flags;
	logic async_clock_select, ext_clock_enable, prescaler_reset;
	logic osc_s1, osc_s2, osc_s3;
	localparam int PRESCALE_BITS_W = atp_pkg::PRESCALE_BITS;
	logic [PRESCALE_BITS_W-1:0] prescale;
	logic count_up, block_match, compare_pending, wave;
	logic count_busy, compare_busy, control_busy;
	logic [1:0] count_edges, compare_edges, control_edges;

	// Tap hit for the selected prescale ratio
	function automatic logic tap_hit(input logic [2:0] sel, input logic [9:0] pre);
		logic [9:0] m;
		m = 10'h000;
		case (sel)
			3'h2: m = 10'h007;
			3'h3: m = 10'h01f;
			3'h4: m = 10'h03f;
			3'h5: m = 10'h07f;
			3'h6: m = 10'h0ff;
			3'h7: m = 10'h3ff;
			default: m = 10'h000;
		endcase
		return (sel != 3'h0) && ((pre & m) == m);
	endfunction : tap_hit

	// Non-PWM output action on a match
	function automatic logic nonpwm_act(input logic [1:0] com, input logic cur);
		case (com)
			2'h1: return ~cur;
			2'h2: return 1'b0;
			2'h3: return 1'b1;
			default: return cur;
		endcase
	endfunction : nonpwm_act

	// Second edge of the oscillator after a write closes the transfer
	function automatic logic lands(input logic busy, input logic rise, input logic [1:0] edges);
		return busy && rise && (edges == atp_pkg::COMMIT_EDGES - 2'h1);
	endfunction : lands

	// Bus decode
	wire wr = PSEL && PENABLE && PWRITE;
	wire [7:0] wdata = PWDATA[7:0];
	wire hit_mask = PADDR == atp_pkg::ADDR_IRQ_MASK;
	wire hit_ctl = PADDR == atp_pkg::ADDR_CONTROL;
	wire hit_cnt = PADDR == atp_pkg::ADDR_COUNT;
	wire hit_cmp = PADDR == atp_pkg::ADDR_COMPARE;
	wire hit_async = PADDR == atp_pkg::ADDR_ASYNC_STATUS;
	wire hit_flags = PADDR == atp_pkg::ADDR_FLAGS;
	wire hit_gen = PADDR == atp_pkg::ADDR_GEN_CONTROL;
	wire mapped = hit_mask | hit_ctl | hit_cnt | hit_cmp | hit_async | hit_flags | hit_gen;
	wire wr_ctl = wr && hit_ctl;
	wire wr_cnt = wr && hit_cnt;
	wire wr_cmp = wr && hit_cmp;

	// Source clock: every I/O cycle, or each synchronized oscillator rise
	// The oscillator must stay below half of REF_CLK or rises are lost
	wire osc_rise = osc_s2 && !osc_s3;
	wire src_tick = async_clock_select ? osc_rise : 1'b1;

	// Transfers into the live registers; in async mode only after two edges
	wire ctl_commit = async_clock_select ? lands(control_busy, osc_rise, control_edges) : wr_ctl;
	wire cnt_commit = async_clock_select ? lands(count_busy, osc_rise, count_edges) : wr_cnt;
	wire cmp_commit = async_clock_select ? lands(compare_busy, osc_rise, compare_edges) : wr_cmp;
	wire [7:0] ctl_src = async_clock_select ? control_tmp : wdata;
	wire [7:0] cnt_src = async_clock_select ? count_tmp : wdata;
	wire [7:0] cmp_src = async_clock_select ? compare_tmp : wdata;

	// Mode decode
	wire [1:0] wgm = {control[atp_pkg::CTL_WGM1_BIT], control[atp_pkg::CTL_WGM0_BIT]};
	wire [1:0] com = control[atp_pkg::CTL_COM_HI:atp_pkg::CTL_COM_LO];
	wire [2:0] cs = control[atp_pkg::CTL_CS_HI:atp_pkg::CTL_CS_LO];
	wire pwm = wgm[0];
	wire [1:0] new_wgm = {ctl_src[atp_pkg::CTL_WGM1_BIT], ctl_src[atp_pkg::CTL_WGM0_BIT]};
	wire [1:0] new_com = ctl_src[atp_pkg::CTL_COM_HI:atp_pkg::CTL_COM_LO];

	// Timer tick from the prescaler
	wire tick = src_tick && ((cs == 3'h1) || tap_hit(cs, prescale));

	// Counter events
	wire at_max = count == atp_pkg::COUNT_MAX;
	wire at_bottom = count == atp_pkg::COUNT_BOTTOM;
	wire cmp_top = compare == atp_pkg::COUNT_MAX;
	wire match = tick && (count == compare) && !block_match;
	wire overflow_ev = tick && ((wgm == atp_pkg::WGM_PHASE_PWM) ? (!count_up && at_bottom)
		: at_max);
	wire top_ev = tick && at_max && (wgm != atp_pkg::WGM_PHASE_PWM || count_up);
	// Force acts on the mode being written, and never in PWM
	wire force_ev = ctl_commit && ctl_src[atp_pkg::CTL_FORCE_BIT] && !new_wgm[0];

	logic [7:0] next_count;
	logic next_count_up;
	always_comb begin
		next_count = count + 8'h01;
		next_count_up = count_up;
		case (wgm)
			atp_pkg::WGM_PHASE_PWM: begin
				if (count_up) begin
					if (at_max) begin
						next_count = count - 8'h01;
						next_count_up = 1'b0;
					end
				end else if (at_bottom) begin
					next_count_up = 1'b1;
				end else begin
					next_count = count - 8'h01;
				end
			end
			atp_pkg::WGM_CLEAR_ON_MATCH: begin
				// Only a real match clears; a forced one never reaches here
				if (match) begin
					next_count = atp_pkg::COUNT_BOTTOM;
				end
			end
			default: next_count = count + 8'h01;
		endcase
	end

	logic next_wave;
	always_comb begin
		next_wave = wave;
		if (force_ev) begin
			next_wave = nonpwm_act(new_com, wave);
		end else begin
			case (wgm)
				atp_pkg::WGM_FAST_PWM: begin
					if (com[1] && top_ev) begin
						next_wave = !com[0];
					end else if (com[1] && match && !cmp_top) begin
						next_wave = com[0];
					end
				end
				atp_pkg::WGM_PHASE_PWM: begin
					if (com[1] && cmp_top && top_ev) begin
						next_wave = !com[0];
					end else if (com[1] && match && !cmp_top) begin
						next_wave = count_up ? com[0] : !com[0];
					end
				end
				default: begin
					if (match) begin
						next_wave = nonpwm_act(com, wave);
					end
				end
			endcase
		end
	end

	// Oscillator synchronizer; the first stage feeds only the second
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_s3 <= 1'b0;
		end else begin
			osc_s1 <= OSC_IN_PIN;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
		end
	end

	// Prescaler; in async mode the reset request waits for an oscillator edge
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			prescale <= '0;
			prescaler_reset <= 1'b0;
		end else if (wr && hit_gen && wdata[atp_pkg::PSR_BIT]) begin
			prescaler_reset <= 1'b1;
		end else if (prescaler_reset && src_tick) begin
			prescale <= '0;
			prescaler_reset <= 1'b0;
		end else if (src_tick) begin
			prescale <= prescale + 10'h001;
		end
	end

	// Software registers and the temporary copies
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			irq_mask <= atp_pkg::MASK_RESET;
			async_clock_select <= 1'b0;
			ext_clock_enable <= 1'b0;
			control_tmp <= atp_pkg::CONTROL_RESET;
			count_tmp <= atp_pkg::COUNT_RESET;
			compare_tmp <= atp_pkg::COMPARE_RESET;
		end else if (wr) begin
			if (hit_mask) begin
				irq_mask <= wdata & 8'h03;
			end
			if (hit_async) begin
				async_clock_select <= wdata[atp_pkg::ASYNC_SEL_BIT];
				ext_clock_enable <= wdata[atp_pkg::EXT_CLK_BIT];
			end
			if (hit_ctl) begin
				control_tmp <= wdata;
			end
			if (hit_cnt) begin
				count_tmp <= wdata;
			end
			if (hit_cmp) begin
				compare_tmp <= wdata;
			end
		end
	end

	// Busy flags: a new write restarts the edge count
	// A write while busy restarts the wait; the older value still lands if that write falls on its landing edge
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			control_busy <= 1'b0;
			count_busy <= 1'b0;
			compare_busy <= 1'b0;
			control_edges <= 2'h0;
			count_edges <= 2'h0;
			compare_edges <= 2'h0;
		end else begin
			control_busy <= (wr_ctl && async_clock_select) || (control_busy && !ctl_commit);
			count_busy <= (wr_cnt && async_clock_select) || (count_busy && !cnt_commit);
			compare_busy <= (wr_cmp && async_clock_select) || (compare_busy && !cmp_commit);
			control_edges <= wr_ctl ? 2'h0 : control_edges + {1'b0, control_busy && osc_rise};
			count_edges <= wr_cnt ? 2'h0 : count_edges + {1'b0, count_busy && osc_rise};
			compare_edges <= wr_cmp ? 2'h0 : compare_edges + {1'b0, compare_busy && osc_rise};
		end
	end

	// Live control, compare buffer and counter
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			control <= atp_pkg::CONTROL_RESET;
			compare <= atp_pkg::COMPARE_RESET;
			compare_buf <= atp_pkg::COMPARE_RESET;
			compare_pending <= 1'b0;
			count <= atp_pkg::COUNT_RESET;
			count_up <= 1'b1;
			block_match <= 1'b0;
			wave <= 1'b0;
		end else begin
			if (ctl_commit) begin
				control <= ctl_src & 8'h7f;
			end
			// PWM modes hold a new compare value until top to avoid glitches
			if (cmp_commit && !pwm) begin
				compare <= cmp_src;
				compare_buf <= cmp_src;
				compare_pending <= 1'b0;
			end else if (cmp_commit) begin
				compare_buf <= cmp_src;
				compare_pending <= 1'b1;
			end else if (compare_pending && (top_ev || !pwm)) begin
				compare <= compare_buf;
				compare_pending <= 1'b0;
			end
			if (cnt_commit) begin
				count <= cnt_src;
				block_match <= 1'b1;
			end else if (tick) begin
				count <= next_count;
				count_up <= next_count_up;
				block_match <= 1'b0;
			end
			wave <= next_wave;
		end
	end

	// Flags: an event in the clearing cycle wins
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			flags <= 2'h0;
		end else begin
			flags[atp_pkg::COMPARE_BIT] <= match || (flags[atp_pkg::COMPARE_BIT]
				&& !COMPARE_VECTOR_ACK && !(wr && hit_flags && wdata[atp_pkg::COMPARE_BIT]));
			flags[atp_pkg::OVERFLOW_BIT] <= overflow_ev || (flags[atp_pkg::OVERFLOW_BIT]
				&& !OVERFLOW_VECTOR_ACK && !(wr && hit_flags && wdata[atp_pkg::OVERFLOW_BIT]));
		end
	end

	// Read mux; control and compare show the temporary copies
	logic [7:0] rd;
	always_comb begin
		rd = 8'h00;
		if (hit_mask) rd = irq_mask;
		if (hit_ctl) rd = control_tmp & 8'h7f;
		if (hit_cnt) rd = count;
		if (hit_cmp) rd = compare_tmp;
		if (hit_flags) rd = {6'h00, flags};
		if (hit_gen) rd = {6'h00, prescaler_reset, 1'b0};
		if (hit_async) rd = {3'h0, ext_clock_enable, async_clock_select, count_busy,
			compare_busy, control_busy};
	end

	// Read data is captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= {24'h000000, rd};
		end
	end

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign OSC_PINS_DETACHED = async_clock_select;
	assign EXT_CLOCK_ENABLE = ext_clock_enable;
	assign WAVE_OUT_PIN = (com != 2'h0) ? wave : PORT_OUT;
	// Direction alone enables the driver, exactly as for a plain port pin
	assign WAVE_OUT_OE = PORT_DIR;
	assign COMPARE_IRQ = GLOBAL_IRQ_EN && irq_mask[atp_pkg::COMPARE_BIT]
		&& flags[atp_pkg::COMPARE_BIT];
	assign OVERFLOW_IRQ = GLOBAL_IRQ_EN && irq_mask[atp_pkg::OVERFLOW_BIT]
		&& flags[atp_pkg::OVERFLOW_BIT];

endmodule : atp_timer

// ==== verification/atp_timer_props.sv ====
`timescale 1ns/100ps
module atp_timer_props (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Register bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	// Pins
	input wire logic OSC_PINS_DETACHED,
	input wire logic PORT_OUT,
	input wire logic PORT_DIR,
	input wire logic WAVE_OUT_PIN,
	input wire logic WAVE_OUT_OE,
	// Interrupt side
	input wire logic GLOBAL_IRQ_EN,
	input wire logic COMPARE_VECTOR_ACK,
	input wire logic OVERFLOW_VECTOR_ACK,
	input wire logic COMPARE_IRQ,
	input wire logic OVERFLOW_IRQ
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	wire bus_wr = PSEL && PENABLE && PWRITE;
	wire ctl_wr = bus_wr && PADDR == atp_pkg::ADDR_CONTROL;
	logic ctl_seen;
	// Output mode is zero until control is first written
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ctl_seen <= 1'b0;
		end else if (ctl_wr) begin
			ctl_seen <= 1'b1;
		end
	end
	// Async mode delays the strobe to the oscillator, so only sync mode is judged
	sequence force_wr(logic [1:0] com);
		ctl_wr && PWDATA[7] && !PWDATA[6] && PWDATA[5:4] == com && !OSC_PINS_DETACHED;
	endsequence
	port_pass_a: assert property (!ctl_seen |-> WAVE_OUT_PIN == PORT_OUT)
		else $error("wave pin not following port data");
	oe_dir_a: assert property (WAVE_OUT_OE == PORT_DIR)
		else $error("output enable differs from direction");
	force_set_a: assert property (force_wr(2'b11) |-> ##[1:2] WAVE_OUT_PIN)
		else $error("forced set did not drive pin high");
	force_clr_a: assert property (force_wr(2'b10) |-> ##[1:2] !WAVE_OUT_PIN)
		else $error("forced clear did not drive pin low");
	force_rd_a: assert property (PSEL && PENABLE && !PWRITE && PADDR == atp_pkg::ADDR_CONTROL
		|-> !PRDATA[atp_pkg::CTL_FORCE_BIT])
		else $error("force bit read as one");
	detach_a: assert property ($changed(OSC_PINS_DETACHED)
		|-> $past(bus_wr && PADDR == atp_pkg::ADDR_ASYNC_STATUS))
		else $error("pins detached without a status write");
	irq_gate_a: assert property (COMPARE_IRQ || OVERFLOW_IRQ |-> GLOBAL_IRQ_EN)
		else $error("interrupt without global enable");
	cmp_drop_a: assert property ($fell(COMPARE_IRQ) |-> $fell(GLOBAL_IRQ_EN)
		|| $past(COMPARE_VECTOR_ACK) || $past(bus_wr))
		else $error("compare request dropped without cause");
	ovf_drop_a: assert property ($fell(OVERFLOW_IRQ) |-> $fell(GLOBAL_IRQ_EN)
		|| $past(OVERFLOW_VECTOR_ACK) || $past(bus_wr))
		else $error("overflow request dropped without cause");
endmodule : atp_timer_props

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic OSC_IN_PIN, OSC_PINS_DETACHED, EXT_CLOCK_ENABLE, PORT_OUT, PORT_DIR;
	logic WAVE_OUT_PIN, WAVE_OUT_OE, GLOBAL_IRQ_EN, COMPARE_VECTOR_ACK, OVERFLOW_VECTOR_ACK;
	logic COMPARE_IRQ, OVERFLOW_IRQ;
	int miscompares, n_checks;
	atp_timer dut_u (
		.REF_CLK(REF_CLK),
		.NRST(NRST),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.OSC_IN_PIN(OSC_IN_PIN),
		.OSC_PINS_DETACHED(OSC_PINS_DETACHED),
		.EXT_CLOCK_ENABLE(EXT_CLOCK_ENABLE),
		.PORT_OUT(PORT_OUT),
		.PORT_DIR(PORT_DIR),
		.WAVE_OUT_PIN(WAVE_OUT_PIN),
		.WAVE_OUT_OE(WAVE_OUT_OE),
		.GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
		.COMPARE_VECTOR_ACK(COMPARE_VECTOR_ACK),
		.OVERFLOW_VECTOR_ACK(OVERFLOW_VECTOR_ACK),
		.COMPARE_IRQ(COMPARE_IRQ),
		.OVERFLOW_IRQ(OVERFLOW_IRQ)
	);
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	task stop_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Setup, access, then wait for ready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		@(posedge REF_CLK);
		while (PREADY !== 1'b1 && n < 8) begin
			@(posedge REF_CLK);
			n++;
		end
		if (n == 8) begin
			miscompares++;
			stop_test();
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdc
	// Oscillator moves only while a test needs it
	task osc(input int n);
		repeat (n) begin
			OSC_IN_PIN <= 1'b1;
			repeat (4) @(posedge REF_CLK);
			OSC_IN_PIN <= 1'b0;
			repeat (4) @(posedge REF_CLK);
		end
	endtask : osc
	task automatic t_reset;
		logic [11:0] a [7] = '{atp_pkg::ADDR_IRQ_MASK, atp_pkg::ADDR_CONTROL,
			atp_pkg::ADDR_COUNT, atp_pkg::ADDR_COMPARE, atp_pkg::ADDR_ASYNC_STATUS,
			atp_pkg::ADDR_FLAGS, atp_pkg::ADDR_GEN_CONTROL};
		foreach (a[i]) rdc("reset value", a[i], 32'h0);
		rdc("unmapped read", 12'h0fc, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
	endtask : t_reset
	// Read windows spaced exactly four ticks apart for each nonzero clock select code; code 0 must not count
	task automatic t_rates;
		int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
		logic [7:0] c0;
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, atp_pkg::ADDR_CONTROL, 32'(k));
			apb(1'b0, atp_pkg::ADDR_COUNT, 32'h0);
			c0 = rd[7:0];
			repeat ((k == 0) ? 5 : 4 * dv[k] - 3) @(posedge REF_CLK);
			apb(1'b0, atp_pkg::ADDR_COUNT, 32'h0);
			chk("count step", (k == 0) ? 32'h0 : 32'h4, {24'h0, 8'(rd[7:0] - c0)});
		end
		apb(1'b1, atp_pkg::ADDR_GEN_CONTROL, 32'h2);
		rdc("prescaler reset done", atp_pkg::ADDR_GEN_CONTROL, 32'h0);
	endtask : t_rates
	task t_ovf;
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h0);
		apb(1'b1, atp_pkg::ADDR_COMPARE, 32'h0);
		apb(1'b1, atp_pkg::ADDR_COUNT, 32'hfd);
		apb(1'b1, atp_pkg::ADDR_FLAGS, 32'h3);
		apb(1'b1, atp_pkg::ADDR_IRQ_MASK, 32'h1);
		GLOBAL_IRQ_EN <= 1'b1;
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h1);
		repeat (4) @(posedge REF_CLK);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h0);
		chk("overflow request", 32'h1, {31'h0, OVERFLOW_IRQ});
		chk("masked compare", 32'h0, {31'h0, COMPARE_IRQ});
		GLOBAL_IRQ_EN <= 1'b0;
		@(posedge REF_CLK);
		chk("global off", 32'h0, {31'h0, OVERFLOW_IRQ});
		GLOBAL_IRQ_EN <= 1'b1;
		OVERFLOW_VECTOR_ACK <= 1'b1;
		@(posedge REF_CLK);
		OVERFLOW_VECTOR_ACK <= 1'b0;
		@(posedge REF_CLK);
		rdc("flags after ack", atp_pkg::ADDR_FLAGS, 32'h2);
		apb(1'b1, atp_pkg::ADDR_FLAGS, 32'h2);
		rdc("flags after clear", atp_pkg::ADDR_FLAGS, 32'h0);
	endtask : t_ovf
	task t_ctc;
		apb(1'b1, atp_pkg::ADDR_COMPARE, 32'h5);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h09);
		repeat (20) @(posedge REF_CLK);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h08);
		apb(1'b1, atp_pkg::ADDR_IRQ_MASK, 32'h2);
		@(posedge REF_CLK);
		chk("compare request", 32'h1, {31'h0, COMPARE_IRQ});
		apb(1'b0, atp_pkg::ADDR_COUNT, 32'h0);
		chk("count below top", 32'h1, {31'h0, rd[7:0] <= 8'h05});
		rdc("match flag only", atp_pkg::ADDR_FLAGS, 32'h2);
	endtask : t_ctc
	task automatic t_force;
		logic [1:0] com [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
		logic [7:0] c0;
		apb(1'b1, atp_pkg::ADDR_FLAGS, 32'h3);
		apb(1'b0, atp_pkg::ADDR_COUNT, 32'h0);
		c0 = rd[7:0];
		foreach (com[i]) begin
			apb(1'b1, atp_pkg::ADDR_CONTROL, {24'h0, 2'b10, com[i], 4'h8});
			repeat (2) @(posedge REF_CLK);
			chk("forced pin", {31'h0, i != 1 && i != 3}, {31'h0, WAVE_OUT_PIN});
		end
		rdc("force reads zero", atp_pkg::ADDR_CONTROL, 32'h18);
		rdc("no flag", atp_pkg::ADDR_FLAGS, 32'h0);
		rdc("count kept", atp_pkg::ADDR_COUNT, {24'h0, c0});
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'hf8);
		repeat (2) @(posedge REF_CLK);
		chk("pwm force ignored", 32'h0, {31'h0, WAVE_OUT_PIN});
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h0);
		PORT_OUT <= 1'b1;
		@(posedge REF_CLK);
		chk("port passes", 32'h1, {31'h0, WAVE_OUT_PIN});
	endtask : t_force
	// A count write suppresses the first match, then fast PWM sets at top
	task t_pwm;
		apb(1'b1, atp_pkg::ADDR_FLAGS, 32'h3);
		apb(1'b1, atp_pkg::ADDR_COMPARE, 32'h80);
		apb(1'b1, atp_pkg::ADDR_COUNT, 32'h80);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h1);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h0);
		rdc("blocked match", atp_pkg::ADDR_FLAGS, 32'h0);
		apb(1'b1, atp_pkg::ADDR_COUNT, 32'hfe);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h69);
		repeat (10) @(posedge REF_CLK);
		chk("set at top", 32'h1, {31'h0, WAVE_OUT_PIN});
		repeat (130) @(posedge REF_CLK);
		chk("clear on match", 32'h0, {31'h0, WAVE_OUT_PIN});
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h0);
	endtask : t_pwm
	task t_async;
		logic [7:0] c0;
		apb(1'b1, atp_pkg::ADDR_ASYNC_STATUS, 32'h18);
		@(posedge REF_CLK);
		chk("pins detached", 32'h1, {31'h0, OSC_PINS_DETACHED});
		chk("ext clock", 32'h1, {31'h0, EXT_CLOCK_ENABLE});
		apb(1'b1, atp_pkg::ADDR_COUNT, 32'h20);
		apb(1'b1, atp_pkg::ADDR_COMPARE, 32'h77);
		rdc("busy set", atp_pkg::ADDR_ASYNC_STATUS, 32'h1e);
		rdc("temp compare", atp_pkg::ADDR_COMPARE, 32'h77);
		osc(2);
		rdc("busy clear", atp_pkg::ADDR_ASYNC_STATUS, 32'h18);
		rdc("count landed", atp_pkg::ADDR_COUNT, 32'h20);
		apb(1'b1, atp_pkg::ADDR_CONTROL, 32'h1);
		osc(2);
		apb(1'b0, atp_pkg::ADDR_COUNT, 32'h0);
		c0 = rd[7:0];
		osc(3);
		apb(1'b0, atp_pkg::ADDR_COUNT, 32'h0);
		chk("osc ticks", 32'h3, {24'h0, 8'(rd[7:0] - c0)});
	endtask : t_async
	initial begin
		NRST = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h0;
		PWDATA = 32'h0;
		OSC_IN_PIN = 1'b0;
		PORT_OUT = 1'b0;
		PORT_DIR = 1'b1;
		GLOBAL_IRQ_EN = 1'b0;
		COMPARE_VECTOR_ACK = 1'b0;
		OVERFLOW_VECTOR_ACK = 1'b0;
		miscompares = 0;
		n_checks = 0;
		repeat (12) @(posedge REF_CLK);
		NRST <= 1'b1;
		t_reset();
		t_rates();
		t_ovf();
		t_ctc();
		t_force();
		t_pwm();
		t_async();
		stop_test();
	end
endmodule : testbench
bind atp_timer atp_timer_props chk_u (
	.REF_CLK(REF_CLK),
	.NRST(NRST),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PWDATA(PWDATA),
	.PRDATA(PRDATA),
	.OSC_PINS_DETACHED(OSC_PINS_DETACHED),
	.PORT_OUT(PORT_OUT),
	.PORT_DIR(PORT_DIR),
	.WAVE_OUT_PIN(WAVE_OUT_PIN),
	.WAVE_OUT_OE(WAVE_OUT_OE),
	.GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
	.COMPARE_VECTOR_ACK(COMPARE_VECTOR_ACK),
	.OVERFLOW_VECTOR_ACK(OVERFLOW_VECTOR_ACK),
	.COMPARE_IRQ(COMPARE_IRQ),
	.OVERFLOW_IRQ(OVERFLOW_IRQ)
);
